//--- hdl/ebc_bus_control.sv
// Bus control configuration register with pin-state control outputs
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module ebc_bus_control (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic                         power_on_rst_n,
    input  wire logic                         byte_order_mode_pin,
    input  wire logic                         standby_mode,
    input  wire logic                         bus_released,
    input  wire logic                         bus_ack,
    input  wire logic                         data_bus_busy,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic      [ebc_pkg::ADDR_PINS-1:0] addrPullupOn,
    output logic      [ebc_pkg::DATA_PINS-1:0] dataPullupOn,
    output logic                              memPinsFloat,
    output logic                              memPinsDriveHigh,
    output logic                              strobeFloat,
    output logic                              littleEndian,
    output logic      [4:0]                   area0BurstLen,
    output logic      [4:0]                   area5BurstLen,
    output logic      [4:0]                   area6BurstLen,
    output logic                              area2Sdram,
    output logic                              area3Sdram,
    output logic                              area5CardSpace,
    output logic                              area6CardSpace,
    output logic                              memTypeIllegal
);
    import ebc_pkg::*;

    logic [15:0] ctrl_ff;
    logic        byteOrder_ff;
    logic [2:0]  pullCnt_ff;
    logic        busAckDly_ff;
    logic [15:0] nxt_ctrl;
    logic [15:0] regView;
    logic [4:0]  len0, len5, len6;
    logic        wrEn, rdEn, hitCtrl, hitStat;
    logic [2:0]  memType;

    assign hitCtrl = (paddr == BUS_CONTROL_ONE_OFFSET);
    assign hitStat = (paddr == BURST_STATUS_OFFSET);
    assign wrEn    = psel && penable && pwrite && hitCtrl;
    assign rdEn    = psel && !penable && !pwrite;
    // Byte order bit always read from the latched copy
    assign regView = {ctrl_ff[15:12], byteOrder_ff, ctrl_ff[10:0]};
    assign memType = ctrl_ff[MEM_TYPE_LSB+2:MEM_TYPE_LSB];

    // Byte lanes merge; read-only bit masked out of the write
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (pstrb[0]) begin
            nxt_ctrl[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            nxt_ctrl[15:8] = pwdata[15:8];
        end
        nxt_ctrl = (nxt_ctrl & BUS_CONTROL_ONE_WMASK) | (ctrl_ff & ~BUS_CONTROL_ONE_WMASK);
    end

    // Only power-on reset clears; rst_n is the manual reset and leaves it alone
    always_ff @(posedge core_clk) begin
        if (!power_on_rst_n) begin
            ctrl_ff <= BUS_CONTROL_ONE_RESET;
        end else if (wrEn) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Strap sampled while power-on reset is held; kept through manual reset
    always_ff @(posedge core_clk) begin
        if (!power_on_rst_n) begin
            byteOrder_ff <= byte_order_mode_pin;
        end
    end

    // Pull-up window starts on the rising edge of bus acknowledge
    always_ff @(posedge core_clk) begin
        if (!rst_n || !power_on_rst_n) begin
            busAckDly_ff <= 1'b0;
            pullCnt_ff   <= 3'h0;
        end else begin
            busAckDly_ff <= bus_ack;
            if (bus_ack && !busAckDly_ff && ctrl_ff[ADDR_PULLUP_BIT]) begin
                pullCnt_ff <= PULLUP_COUNT;
            end else if (pullCnt_ff != 3'h0) begin
                pullCnt_ff <= pullCnt_ff - 3'h1;
            end
        end
    end

    ebc_burst_decode u_dec0 (.burstCode(ctrl_ff[AREA0_BURST_LSB+1:AREA0_BURST_LSB]),
                             .burstLen(len0));
    ebc_burst_decode u_dec5 (.burstCode(ctrl_ff[AREA5_BURST_LSB+1:AREA5_BURST_LSB]),
                             .burstLen(len5));
    ebc_burst_decode u_dec6 (.burstCode(ctrl_ff[AREA6_BURST_LSB+1:AREA6_BURST_LSB]),
                             .burstLen(len6));

    // Pin controls registered so every output leaves a flip-flop
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addrPullupOn     <= '0;
            dataPullupOn     <= '0;
            memPinsFloat     <= 1'b0;
            memPinsDriveHigh <= 1'b0;
            strobeFloat      <= 1'b0;
        end else begin
            addrPullupOn <= {ADDR_PINS{pullCnt_ff != 3'h0}};
            dataPullupOn <= {DATA_PINS{ctrl_ff[DATA_PULLUP_BIT] && !data_bus_busy}};
            memPinsFloat     <= standby_mode && !ctrl_ff[STANDBY_MEM_BIT];
            memPinsDriveHigh <= standby_mode && ctrl_ff[STANDBY_MEM_BIT];
            strobeFloat <= (standby_mode || bus_released) && !ctrl_ff[STROBE_FLOAT_BIT];
        end
    end

    // Decoded area configuration for the bus-cycle engines
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            littleEndian   <= 1'b0;
            area0BurstLen  <= 5'h00;
            area5BurstLen  <= 5'h00;
            area6BurstLen  <= 5'h00;
            area2Sdram     <= 1'b0;
            area3Sdram     <= 1'b0;
            area5CardSpace <= 1'b0;
            area6CardSpace <= 1'b0;
            memTypeIllegal <= 1'b0;
        end else begin
            littleEndian   <= byteOrder_ff;
            area0BurstLen  <= len0;
            area5BurstLen  <= len5;
            area6BurstLen  <= len6;
            // Prohibited codes fall back to ordinary memory and are flagged
            area2Sdram     <= (memType == MEM_TYPE_BOTH_SD);
            area3Sdram     <= (memType == MEM_TYPE_BOTH_SD) ||
                              (memType == MEM_TYPE_AREA3_SD);
            memTypeIllegal <= (memType != MEM_TYPE_ORDINARY) &&
                              (memType != MEM_TYPE_AREA3_SD) &&
                              (memType != MEM_TYPE_BOTH_SD);
            area5CardSpace <= ctrl_ff[AREA5_CARD_BIT];
            area6CardSpace <= ctrl_ff[AREA6_CARD_BIT];
        end
    end

    // APB slave: no wait states, read data captured in setup cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(hitCtrl || hitStat);
            if (rdEn && hitCtrl) begin
                prdata <= {16'h0000, regView};
            end else if (rdEn && hitStat) begin
                prdata <= {17'h00000, len6, len5, len0};
            end else if (psel && !penable) begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule

//--- inc/ebc_pkg.sv
// Package with the register map, field layout and timing of the bus control configuration block
// Contract
// - Power-on reset clears register; manual reset, standby keep
// - Address pull-up four cycles after bus acknowledge
// - Data pull-up while data pins idle
// - Standby memory pins float or drive high
// - Row/column strobes float or driven when released
// - Byte-order pin latched at power-on reset
// - Area zero burst count select
// - Area five burst count select
// - Area six burst count select
// - Memory type code for areas two, three
// - Card space select for areas five, six
package ebc_pkg;
    localparam logic [11:0] BUS_CONTROL_ONE_OFFSET = 12'h000;
    localparam logic [11:0] BURST_STATUS_OFFSET    = 12'h004;
    localparam logic [15:0] BUS_CONTROL_ONE_RESET  = 16'h0000;
    localparam logic [15:0] BUS_CONTROL_ONE_WMASK  = 16'hF7FF;
    localparam int ADDR_PULLUP_BIT   = 15;
    localparam int DATA_PULLUP_BIT   = 14;
    localparam int STANDBY_MEM_BIT   = 13;
    localparam int STROBE_FLOAT_BIT  = 12;
    localparam int BYTE_ORDER_BIT    = 11;
    localparam int AREA0_BURST_LSB   = 9;
    localparam int AREA5_BURST_LSB   = 7;
    localparam int AREA6_BURST_LSB   = 5;
    localparam int MEM_TYPE_LSB      = 2;
    localparam int AREA5_CARD_BIT    = 1;
    localparam int AREA6_CARD_BIT    = 0;
    localparam int ADDR_PINS         = 26;
    localparam int DATA_PINS         = 32;
    localparam int PULLUP_CYCLES     = 4;
    localparam logic [2:0] PULLUP_COUNT = 3'(PULLUP_CYCLES);
    localparam logic [2:0] MEM_TYPE_ORDINARY  = 3'h0;
    localparam logic [2:0] MEM_TYPE_AREA3_SD  = 3'h2;
    localparam logic [2:0] MEM_TYPE_BOTH_SD   = 3'h3;
    typedef enum logic [1:0] {
        BURST_NONE = 2'h0,
        BURST_4    = 2'h1,
        BURST_8    = 2'h2,
        BURST_16   = 2'h3
    } ebc_burst_t;
endpackage

//--- hdl/ebc_burst_decode.sv
// Burst code to consecutive-access count decoder
`timescale 1ns/1ps
module ebc_burst_decode (
    input  wire logic [1:0] burstCode,
    output logic      [4:0] burstLen
);
    import ebc_pkg::*;
    // Zero means ordinary memory, no burst
    always_comb begin
        case (burstCode)
            BURST_4:  burstLen = 5'h04;
            BURST_8:  burstLen = 5'h08;
            BURST_16: burstLen = 5'h10;
            default:  burstLen = 5'h00;
        endcase
    end
endmodule

//--- verification/ebc_bus_control_chk.sv
// Checker of pin timing and bus answers of the bus control block
`timescale 1ns/1ps
module ebc_bus_control_chk (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        standby_mode,
    input wire logic        bus_released,
    input wire logic        bus_ack,
    input wire logic        data_bus_busy,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [25:0] addrPullupOn,
    input wire logic [31:0] dataPullupOn,
    input wire logic        memPinsFloat,
    input wire logic        memPinsDriveHigh,
    input wire logic        strobeFloat
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // A restart only lengthens the window, so four cycles is a floor
    sequence s_pullHold; addrPullupOn[0] [*4]; endsequence
    property p_pullLen; $rose(addrPullupOn[0]) |-> s_pullHold; endproperty
    a_pullLen: assert property (p_pullLen) else $error("short pull-up");
    property p_pullCause;
        $rose(addrPullupOn[0]) |-> $past(bus_ack, 2) && !$past(bus_ack, 3);
    endproperty
    a_pullCause: assert property (p_pullCause) else $error("stray pull-up");
    property p_dataPull; dataPullupOn[0] |-> !$past(data_bus_busy); endproperty
    a_dataPull: assert property (p_dataPull) else $error("pull on busy bus");
    property p_memPins;
        $past(rst_n) |-> (memPinsFloat | memPinsDriveHigh) == $past(standby_mode)
            && !(memPinsFloat & memPinsDriveHigh);
    endproperty
    a_memPins: assert property (p_memPins) else $error("bad standby pins");
    property p_strobe; strobeFloat |-> $past(standby_mode | bus_released); endproperty
    a_strobe: assert property (p_strobe) else $error("strobe float");
    property p_apbAns; psel && !penable |=> pready; endproperty
    a_apbAns: assert property (p_apbAns) else $error("late answer");
    property p_apbOne; pready |=> !pready; endproperty
    a_apbOne: assert property (p_apbOne) else $error("long answer");
    property p_apbIdle; !psel |=> !pready; endproperty
    a_apbIdle: assert property (p_apbIdle) else $error("answer unasked");
endmodule

//--- verification/ebc_mem_model.sv
// Far side: bus grant on request and a data bus busy at random
`timescale 1ns/1ps
module ebc_mem_model (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic ackReq,
    output logic      bus_ack,
    output logic      data_bus_busy
);
    // Quiet through reset so no grant edge is seen at release
    initial {bus_ack, data_bus_busy} = 2'b00;
    always @(posedge core_clk) begin
        bus_ack <= rst_n & ackReq;
        data_bus_busy <= rst_n & ($urandom % 3 == 0);
    end
endmodule

//--- verification/ebc_bus_control_tb.sv
// Self-checking bench of the bus control configuration block
`timescale 1ns/1ps
module ebc_bus_control_tb;
    import ebc_pkg::*;
    logic        core_clk, rst_n, power_on_rst_n, byte_order_mode_pin, standby_mode;
    logic        bus_released, bus_ack, data_bus_busy, ackReq, psel, penable, pwrite;
    logic        pready, pslverr, memPinsFloat, memPinsDriveHigh, strobeFloat, littleEndian;
    logic        area2Sdram, area3Sdram, area5CardSpace, area6CardSpace, memTypeIllegal, err;
    logic        busyPrev;
    int          bad;
    logic [3:0]  pstrb;
    logic [4:0]  area0BurstLen, area5BurstLen, area6BurstLen;
    logic [11:0] paddr;
    logic [25:0] addrPullupOn;
    logic [31:0] pwdata, prdata, dataPullupOn, rd;
    logic [15:0] w, v;
    int          nErrors, nCompared, k;
    ebc_bus_control ebc_bus_control_inst (.*);
    ebc_mem_model ebc_mem_model_inst (.*);
    function automatic logic [4:0] blen(input logic [1:0] c);
        return (c == 2'h0) ? 5'h00 : 5'h02 << c;
    endfunction
    function automatic logic [2:0] mt(input logic [2:0] c);
        return {c == 3'h3, c[2:1] == 2'b01, !(c inside {3'h0, 3'h2, 3'h3})};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // One transfer; the request stands until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Write, read back, then check decodes and pin states
    task automatic cfg(input logic [15:0] d);
        apb(1'b1, BUS_CONTROL_ONE_OFFSET, d);
        w = (d & BUS_CONTROL_ONE_WMASK) | {4'h0, byte_order_mode_pin, 11'h000};
        apb(1'b0, BUS_CONTROL_ONE_OFFSET, 16'h0000);
        chk(rd, {16'h0000, w});
        apb(1'b0, BURST_STATUS_OFFSET, 16'h0000);
        chk(rd, 32'({blen(w[6:5]), blen(w[8:7]), blen(w[10:9])}));
        chk(32'({area0BurstLen, area5BurstLen}), 32'({blen(w[10:9]), blen(w[8:7])}));
        chk(32'(area6BurstLen), 32'(blen(w[6:5])));
        chk(32'({area2Sdram, area3Sdram, memTypeIllegal}), 32'(mt(w[4:2])));
        chk(32'({area5CardSpace, area6CardSpace}), 32'(w[1:0]));
        standby_mode <= 1'($urandom);
        bus_released <= 1'($urandom);
        repeat (2) @(posedge core_clk);
        chk(32'(memPinsFloat), 32'(standby_mode & !w[13]));
        chk(32'(memPinsDriveHigh), 32'(standby_mode & w[13]));
        chk(32'(strobeFloat), 32'((standby_mode | bus_released) & !w[12]));
        ackReq <= 1'b1;
        k = 0;
        bad = 0;
        busyPrev = 1'b0;
        // Data pull-up lags the busy level seen at the previous edge by one cycle
        for (int j = 0; j < 8; j++) begin
            @(posedge core_clk);
            k += int'(addrPullupOn[0] === 1'b1);
            if (j > 0 && dataPullupOn !== {32{w[14] & !busyPrev}}) begin
                bad++;
            end
            busyPrev = data_bus_busy;
        end
        ackReq <= 1'b0;
        chk(32'(k), w[15] ? 32'h4 : 32'h0);
        chk(32'(bad), 32'h0);
    endtask
    task automatic stopTest();
        $display("compared %0d, errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Watchdog well past the few hundred cycles the run needs
    initial begin
        #100000;
        nErrors++;
        stopTest();
    end
    initial begin
        {rst_n, power_on_rst_n, psel, penable, pwrite, ackReq, standby_mode, bus_released} = '0;
        {paddr, pwdata, pstrb, byte_order_mode_pin} = {12'h000, 32'h0, 4'hF, 1'b1};
        {nErrors, nCompared} = '0;
        void'($urandom(32'h68F0));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        power_on_rst_n <= 1'b1;
        apb(1'b0, BUS_CONTROL_ONE_OFFSET, 16'h0000);
        chk(rd, 32'h0000_0800);
        chk(32'(littleEndian), 32'h1);
        // Register set up after the reset-value read, before any other traffic
        // Area widths live outside this block; codes sweep every value
        for (int i = 0; i < 16; i++) begin
            v = 16'($urandom);
            v[10:2] = {i[1:0], i[3:2], ~i[1:0], i[2:0]};
            cfg(v);
        end
        apb(1'b1, 12'h008, 16'hFFFF);
        chk(32'(err), 32'h1);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, BUS_CONTROL_ONE_OFFSET, 16'h0000);
        chk(rd, {16'h0000, w});
        power_on_rst_n <= 1'b0;
        rst_n <= 1'b0;
        byte_order_mode_pin <= 1'b0;
        repeat (2) @(posedge core_clk);
        {rst_n, power_on_rst_n} <= 2'b11;
        apb(1'b0, BUS_CONTROL_ONE_OFFSET, 16'h0000);
        chk(rd, 32'h0);
        stopTest();
    end
endmodule
bind ebc_bus_control ebc_bus_control_chk ebc_bus_control_chk_inst (.*);
